/* File: design/iob_device.sv */
// device end: programmed io on code 6 and block channel on code 7
`timescale 1ns/1ps
`default_nettype none
`include "iob_map.svh"
module iob_device (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // io bus
    iob_if.dev bus,
    // indicator
    output logic [15:0] lamp_word,
    // altimeter, switch and radar inputs
    input wire logic [2:0] radar_lines,
    input wire logic radar_fitted,
    input wire logic [2:0] sens_level,
    input wire logic [9:0] altitude_code,
    // channel peripheral side
    input wire logic [1:0] mcu_status,
    input wire logic range_window_closed,
    input wire logic chan_user_req,
    input wire logic [15:0] chan_word_in,
    output logic [15:0] chan_word_out,
    output logic chan_word_strobe,
    output logic [3:0] chan_dev_select,
    output logic chan_busy
);
    import iob_pkg::*;

    iob_dev_t d_reg;
    iob_dev_t d_next;
    logic pio_hit;
    logic dch_hit;
    logic start_p;
    logic clear_p;
    logic p_p;
    logic bus_rst;
    logic finish;
    logic busy;
    logic done;
    logic int_dis;
    logic int_req;
    logic [2:0] radar_eff;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    assign pio_hit = (bus.code == `IOB_CODE_PIO);
    assign dch_hit = (bus.code == `IOB_CODE_DCH);
    // code 6 has no flag logic, so pulses addressed to it reach nothing
    assign start_p = dch_hit && (bus.ctl == ctl_start);
    assign clear_p = dch_hit && (bus.ctl == ctl_clear);
    assign p_p = dch_hit && (bus.ctl == ctl_pulse_p);
    assign bus_rst = (bus.op == op_bus_reset);
    assign finish = (d_reg.ch_state == ch_data) && bus.dch_data_stb && (d_reg.word_count == `IOB_COUNT_LAST);
    // absent radar reads as above every threshold
    assign radar_eff = radar_lines | {3{~radar_fitted}};

    iob_flags u_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start_pulse(start_p),
        .clear_pulse(clear_p),
        .bus_reset(bus_rst),
        .mask_load(bus.op == op_mask_out),
        .mask_value(bus.dout[`IOB_MASK_IDX]),
        .finish(finish),
        .busy(busy),
        .done(done),
        .int_dis(int_dis)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and priority chains

    assign int_req = (done | d_reg.range_done) & ~int_dis;
    assign bus.int_req = int_req;
    assign bus.int_prio_out = bus.int_prio_in & ~int_req;
    assign bus.dch_req = (d_reg.ch_state == ch_req);
    assign bus.dch_prio_out = bus.dch_prio_in & ~bus.dch_req;
    assign bus.dch_dir = d_reg.chan_dev[0];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d_next = d_reg;
        d_next.rd_data = `IOB_RST_WORD;
        d_next.rd_oe = 1'b0;
        d_next.skip_busy = 1'b0;
        d_next.skip_done = 1'b0;
        d_next.user_strobe = 1'b0;

        if (bus_rst || clear_p || p_p) begin
            d_next.range_done = 1'b0;
        end
        if (range_window_closed) begin
            d_next.range_done = 1'b1;
        end

        case (bus.op)
            op_write_a: begin
                if (pio_hit) begin
                    d_next.lamp_word = bus.dout;
                end else if (dch_hit) begin
                    d_next.chan_addr = bus.dout;
                end
            end
            op_write_b: begin
                if (dch_hit) begin
                    d_next.word_count = bus.dout;
                end
            end
            op_write_c: begin
                if (dch_hit) begin
                    d_next.chan_dev = bus.dout[3:0];
                end
            end
            op_read_a: begin
                if (pio_hit) begin
                    d_next.rd_data = {radar_eff[0], radar_eff[1], sens_level, radar_eff[2],
                        altitude_code};
                    d_next.rd_oe = 1'b1;
                end else if (dch_hit) begin
                    d_next.rd_data = d_reg.chan_addr;
                    d_next.rd_oe = 1'b1;
                end
            end
            op_read_b: begin
                if (dch_hit) begin
                    d_next.rd_data = {mcu_status, 10'h000, d_reg.chan_dev};
                end
                d_next.rd_oe = pio_hit || dch_hit;
            end
            op_read_c: begin
                if (dch_hit) begin
                    d_next.rd_data = {12'h000, d_reg.chan_dev};
                end
                d_next.rd_oe = pio_hit || dch_hit;
            end
            op_skip_test: begin
                if (dch_hit) begin
                    d_next.skip_busy = busy;
                    d_next.skip_done = done;
                end
            end
            op_interrupt_acknowledge: begin
                if (int_req && bus.int_prio_in) begin
                    d_next.rd_data = {10'h000, `IOB_CODE_DCH};
                    d_next.rd_oe = 1'b1;
                end
            end
            default: begin
            end
        endcase

        // a clear only stops new requests; a granted cycle runs to its end
        case (d_reg.ch_state)
            ch_idle: begin
                if (busy && chan_user_req) begin
                    d_next.ch_state = ch_req;
                end
            end
            ch_req: begin
                if (bus.dch_ack && bus.dch_prio_in) begin
                    d_next.ch_state = ch_addr;
                end
            end
            ch_addr: begin
                if (bus.dch_addr_stb) begin
                    d_next.rd_data = d_reg.chan_addr;
                    d_next.rd_oe = 1'b1;
                    d_next.ch_state = ch_data;
                end
            end
            ch_data: begin
                if (bus.dch_data_stb) begin
                    if (d_reg.chan_dev[0]) begin
                        d_next.rd_data = chan_word_in;
                        d_next.rd_oe = 1'b1;
                    end else begin
                        d_next.user_word = bus.dout;
                    end
                    d_next.user_strobe = 1'b1;
                    d_next.chan_addr = d_reg.chan_addr + 16'h0001;
                    d_next.word_count = d_reg.word_count + 16'h0001;
                    d_next.ch_state = ch_idle;
                end
            end
            default: begin
                d_next.ch_state = ch_idle;
            end
        endcase

        if (bus_rst) begin
            d_next.ch_state = ch_idle;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus.din = d_reg.rd_data;
    assign bus.din_oe = d_reg.rd_oe;
    assign bus.skip_busy = d_reg.skip_busy;
    assign bus.skip_done = d_reg.skip_done;
    assign lamp_word = d_reg.lamp_word;
    assign chan_word_out = d_reg.user_word;
    assign chan_word_strobe = d_reg.user_strobe;
    assign chan_dev_select = d_reg.chan_dev;
    assign chan_busy = busy;
endmodule
`default_nettype wire

/* File: design/iob_flags.sv */
// busy, done and interrupt-disable flags of one device code
`timescale 1ns/1ps
`default_nettype none
module iob_flags (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control pulses; start and clear already qualified by device code, bus reset and mask load not
    input wire logic start_pulse,
    input wire logic clear_pulse,
    input wire logic bus_reset,
    input wire logic mask_load,
    input wire logic mask_value,
    input wire logic finish,
    // flags
    output logic busy,
    output logic done,
    output logic int_dis
);
    import iob_pkg::*;

    iob_flags_t f_reg;
    iob_flags_t f_next;

    always_comb begin
        f_next = f_reg;
        if (bus_reset) begin
            f_next = '0;
        end else if (clear_pulse) begin
            f_next.busy = 1'b0;
            f_next.done = 1'b0;
        end else if (start_pulse) begin
            f_next.busy = 1'b1;
            f_next.done = 1'b0;
        end
        // completion beats a clear in the same cycle so the event is kept
        if (finish && f_reg.busy && !start_pulse && !bus_reset) begin
            f_next.busy = 1'b0;
            f_next.done = 1'b1;
        end
        if (mask_load) begin
            f_next.int_dis = mask_value;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    assign busy = f_reg.busy;
    assign done = f_reg.done;
    assign int_dis = f_reg.int_dis;
endmodule
`default_nettype wire

/* File: design/iob_host.sv */
// cpu end: issues io instructions from software and serves channel cycles from its memory
`timescale 1ns/1ps
`default_nettype none
`include "iob_map.svh"
module iob_host (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // software port
    input wire logic [2:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata,
    // io bus
    iob_if.cpu bus
);
    import iob_pkg::*;

    iob_host_t h_reg;
    iob_host_t h_next;
    logic [15:0] mem [0:255];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        h_next = h_reg;
        h_next.op = op_none;
        h_next.ctl = ctl_none;
        h_next.ack = 1'b0;
        h_next.astb = 1'b0;
        h_next.dstb = 1'b0;
        h_next.rdata = `IOB_RST_WORD;

        // the answer stands in the cycle after the instruction was on the bus,
        // so the wait flag trails the op register by one cycle
        h_next.ans_wait = (h_reg.op != op_none);
        if (h_reg.ans_wait) begin
            if (bus.din_oe) begin
                h_next.result = bus.din;
            end
            h_next.skip_busy = bus.skip_busy;
            h_next.skip_done = bus.skip_done;
        end

        case (h_reg.st)
            h_idle: begin
                if (h_reg.cmd_pend) begin
                    h_next.op = h_reg.pend_op;
                    h_next.ctl = h_reg.pend_ctl;
                    h_next.code = h_reg.pend_code;
                    h_next.dout = h_reg.data_reg;
                    h_next.cmd_pend = 1'b0;
                end else if (bus.dch_req && bus.dch_prio_out == 1'b0) begin
                    h_next.ack = 1'b1;
                    h_next.st = h_ack;
                end
            end
            h_ack: begin
                h_next.astb = 1'b1;
                h_next.st = h_astb;
            end
            h_astb: begin
                h_next.st = h_awt;
            end
            h_awt: begin
                h_next.chan_mem_addr = bus.din[7:0];
                h_next.dout = mem[bus.din[7:0]];
                h_next.dstb = 1'b1;
                h_next.st = h_dstb;
            end
            h_dstb: begin
                h_next.st = h_dwt;
            end
            default: begin
                h_next.st = h_idle;
            end
        endcase

        if (sw_wr) begin
            if (sw_addr == `IOB_REG_CMD) begin
                if (!h_reg.cmd_pend) begin
                    h_next.pend_code = sw_wdata[`IOB_CMD_CODE_LSB +: 6];
                    h_next.pend_op = iob_op_t'(sw_wdata[`IOB_CMD_OP_LSB +: 4]);
                    h_next.pend_ctl = iob_ctl_t'(sw_wdata[`IOB_CMD_CTL_LSB +: 2]);
                    h_next.cmd_pend = 1'b1;
                end
            end else if (sw_addr == `IOB_REG_DATA) begin
                h_next.data_reg = sw_wdata;
            end else if (sw_addr == `IOB_REG_MEM_ADDR) begin
                h_next.mem_addr = sw_wdata[7:0];
            end
        end

        if (sw_rd) begin
            if (sw_addr == `IOB_REG_DATA) begin
                h_next.rdata = h_reg.data_reg;
            end else if (sw_addr == `IOB_REG_RESULT) begin
                h_next.rdata = h_reg.result;
            end else if (sw_addr == `IOB_REG_STATUS) begin
                h_next.rdata = {10'h000, h_reg.st != h_idle, h_reg.skip_done, h_reg.skip_busy,
                    bus.int_req, h_reg.ans_wait, h_reg.cmd_pend};
            end else if (sw_addr == `IOB_REG_MEM_ADDR) begin
                h_next.rdata = {8'h00, h_reg.mem_addr};
            end else if (sw_addr == `IOB_REG_MEM_DATA) begin
                h_next.rdata = mem[h_reg.mem_addr];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            h_reg <= '0;
        end else begin
            h_reg <= h_next;
        end
    end

    // a channel store takes the port over a software store in the same cycle
    always_ff @(posedge sys_clk) begin
        if (h_reg.st == h_dwt && bus.dch_dir) begin
            mem[h_reg.chan_mem_addr] <= bus.din;
        end else if (sw_wr && sw_addr == `IOB_REG_MEM_DATA) begin
            mem[h_reg.mem_addr] <= sw_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus.op = h_reg.op;
    assign bus.ctl = h_reg.ctl;
    assign bus.code = h_reg.code;
    assign bus.dout = h_reg.dout;
    assign bus.dch_ack = h_reg.ack;
    assign bus.dch_addr_stb = h_reg.astb;
    assign bus.dch_data_stb = h_reg.dstb;
    assign bus.int_prio_in = 1'b1;
    assign bus.dch_prio_in = 1'b1;
    assign sw_rdata = h_reg.rdata;
endmodule
`default_nettype wire

/* File: design/iob_if.sv */
// io bus between the cpu end and the device end
`timescale 1ns/1ps
`default_nettype none
interface iob_if;
    logic [5:0] code;
    logic [15:0] dout;
    iob_pkg::iob_op_t op;
    iob_pkg::iob_ctl_t ctl;
    logic int_prio_in;
    logic dch_prio_in;
    logic dch_ack;
    logic dch_addr_stb;
    logic dch_data_stb;
    logic [15:0] din;
    logic din_oe;
    logic skip_busy;
    logic skip_done;
    logic int_req;
    logic int_prio_out;
    logic dch_req;
    logic dch_prio_out;
    logic dch_dir;

    modport cpu (output code, dout, op, ctl, int_prio_in, dch_prio_in, dch_ack, dch_addr_stb, dch_data_stb,
        input din, din_oe, skip_busy, skip_done, int_req, int_prio_out, dch_req, dch_prio_out, dch_dir);
    modport dev (input code, dout, op, ctl, int_prio_in, dch_prio_in, dch_ack, dch_addr_stb, dch_data_stb,
        output din, din_oe, skip_busy, skip_done, int_req, int_prio_out, dch_req, dch_prio_out, dch_dir);
endinterface
`default_nettype wire

/* File: design/iob_map.svh */
// constants of the io bus channel and programmed io port
`ifndef IOB_MAP_SVH
`define IOB_MAP_SVH

// device codes answered by the card
`define IOB_CODE_PIO 6'h06
`define IOB_CODE_DCH 6'h07

// mask bit 8 counted from the msb is data bit 7
`define IOB_MASK_IDX 7

// word count value that completes the block on its next word
`define IOB_COUNT_LAST 16'hffff

// lamp word bits, bus bit 15 is the lsb of the vector
`define IOB_LAMP_CLIMB 0
`define IOB_LAMP_LEVEL 1
`define IOB_LAMP_DESCEND 2
`define IOB_LAMP_NO_TURN 3
`define IOB_LAMP_NO_CLIMB 7
`define IOB_LAMP_NO_DESCEND 8
`define IOB_LAMP_FLAG_LSB 12
`define IOB_LAMP_SPARE_LSB 14

// input word fields
`define IOB_IN_RADAR_LOW 15
`define IOB_IN_RADAR_MID 14
`define IOB_IN_SENS_LSB 11
`define IOB_IN_RADAR_HIGH 10
`define IOB_IN_ALT_TOP 9

// channel status word fields
`define IOB_STAT_MCU_LSB 14
`define IOB_STAT_DEV_LSB 0

// controller register offsets
`define IOB_REG_CMD 3'h0
`define IOB_REG_DATA 3'h1
`define IOB_REG_RESULT 3'h2
`define IOB_REG_STATUS 3'h3
`define IOB_REG_MEM_ADDR 3'h4
`define IOB_REG_MEM_DATA 3'h5

// command register fields
`define IOB_CMD_CODE_LSB 0
`define IOB_CMD_OP_LSB 8
`define IOB_CMD_CTL_LSB 12

// reset values
`define IOB_RST_WORD 16'h0000

`endif

/* File: design/iob_pkg.sv */
// types shared by both ends of the io bus
package iob_pkg;
    typedef enum logic [3:0] {op_none, op_write_a, op_write_b, op_write_c, op_read_a, op_read_b,
        op_read_c, op_no_transfer, op_skip_test, op_mask_out, op_interrupt_acknowledge,
        op_bus_reset} iob_op_t;
    typedef enum logic [1:0] {ctl_none, ctl_start, ctl_clear, ctl_pulse_p} iob_ctl_t;
    typedef enum logic [1:0] {ch_idle, ch_req, ch_addr, ch_data} iob_ch_state_t;
    typedef enum logic [2:0] {h_idle, h_ack, h_astb, h_awt, h_dstb, h_dwt} iob_host_state_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic int_dis;
    } iob_flags_t;

    typedef struct packed {
        logic [15:0] lamp_word;
        logic [15:0] chan_addr;
        logic [15:0] word_count;
        logic [3:0] chan_dev;
        logic range_done;
        logic [15:0] rd_data;
        logic rd_oe;
        logic skip_busy;
        logic skip_done;
        iob_ch_state_t ch_state;
        logic [15:0] user_word;
        logic user_strobe;
    } iob_dev_t;

    typedef struct packed {
        iob_host_state_t st;
        iob_op_t op;
        iob_ctl_t ctl;
        logic [5:0] code;
        logic [15:0] dout;
        logic ack;
        logic astb;
        logic dstb;
        logic cmd_pend;
        iob_op_t pend_op;
        iob_ctl_t pend_ctl;
        logic [5:0] pend_code;
        logic [15:0] data_reg;
        logic [15:0] result;
        logic skip_busy;
        logic skip_done;
        logic ans_wait;
        logic [7:0] mem_addr;
        logic [7:0] chan_mem_addr;
        logic [15:0] rdata;
    } iob_host_t;
endpackage

/* File: verification/io_bus_channel_and_pio_port_tb_top.sv */
// self-checking bench joining the cpu end and the device end
`timescale 1ns/1ps
`default_nettype none
module io_bus_channel_and_pio_port_tb_top;
    import iob_pkg::*;
    logic sys_clk, sys_rst, sw_wr, sw_rd, radar_fitted, chan_user_req, chan_word_strobe, chan_busy, chk_out;
    logic [2:0] sw_addr, radar_lines, sens_level, r;
    logic [15:0] sw_wdata, sw_rdata, lamp_word, chan_word_in, chan_word_out, rd_val;
    logic [9:0] altitude_code;
    logic [3:0] chan_dev_select;
    logic [15:0] exp_word [0:1];
    int error_cnt, samples_checked, wcnt;
    iob_if bus_if ();
    iob_host u_iob_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus_if.cpu));
    iob_device u_iob_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_if.dev), .lamp_word(lamp_word),
        .radar_lines(radar_lines), .radar_fitted(radar_fitted), .sens_level(sens_level),
        .altitude_code(altitude_code), .mcu_status(2'b10), .range_window_closed(1'b0),
        .chan_user_req(chan_user_req), .chan_word_in(chan_word_in), .chan_word_out(chan_word_out),
        .chan_word_strobe(chan_word_strobe), .chan_dev_select(chan_dev_select), .chan_busy(chan_busy));
    iob_sva u_iob_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .code(bus_if.code), .dout(bus_if.dout),
        .op(bus_if.op), .int_prio_in(bus_if.int_prio_in), .dch_prio_in(bus_if.dch_prio_in),
        .dch_ack(bus_if.dch_ack), .dch_addr_stb(bus_if.dch_addr_stb), .din(bus_if.din), .din_oe(bus_if.din_oe),
        .skip_busy(bus_if.skip_busy), .skip_done(bus_if.skip_done), .int_req(bus_if.int_req),
        .int_prio_out(bus_if.int_prio_out), .dch_req(bus_if.dch_req), .dch_prio_out(bus_if.dch_prio_out));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        #1 rd_val = sw_rdata;
    endtask
    // op goes out one cycle after the command write, the answer one cycle later
    task automatic cmd(input logic [5:0] c, input logic [3:0] o, input logic [1:0] k, input logic [15:0] d);
        wr(3'h1, d);
        wr(3'h0, {2'b00, k, o, 2'b00, c});
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic wait_words(input int n);
        for (int i = 0; i < 200 && wcnt < n; i++) begin
            @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask
    // words leaving memory are compared away from the edge that updates them
    always @(negedge sys_clk) begin
        if (chan_word_strobe === 1'b1) begin
            if (chk_out) begin
                check(chan_word_out, exp_word[wcnt[0]]);
            end
            wcnt++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        rd(3'h3);
        check(rd_val, 16'h0000);
        check(lamp_word, 16'h0000);
    endtask
    task automatic t_lamp();
        cmd(6'h06, 4'h1, 2'h0, 16'ha5c3);
        check(lamp_word, 16'ha5c3);
        cmd(6'h07, 4'h1, 2'h0, 16'h5a5a);
        for (int k = 1; k < 4; k++) begin
            cmd(6'h06, 4'h7, 2'(k), 16'h0000);
        end
        cmd(6'h06, 4'h8, 2'h0, 16'h0000);
        rd(3'h3);
        check(rd_val & 16'h003c, 16'h0000);
        check(lamp_word, 16'ha5c3);
    endtask
    task automatic t_input();
        for (int s = 0; s < 5; s++) begin
            @(posedge sys_clk);
            sens_level <= 3'(s);
            radar_fitted <= s[0];
            altitude_code <= 10'h2a5 ^ 10'(s);
            cmd(6'h06, 4'h4, 2'h0, 16'h0000);
            rd(3'h2);
            r = s[0] ? radar_lines : 3'b111;
            check(rd_val, {r[0], r[1], 3'(s), r[2], 10'h2a5 ^ 10'(s)});
        end
    endtask
    task automatic t_chan_out();
        wr(3'h4, 16'h0010);
        wr(3'h5, exp_word[0]);
        wr(3'h4, 16'h0011);
        wr(3'h5, exp_word[1]);
        chk_out = 1'b1;
        cmd(6'h07, 4'h3, 2'h0, 16'h0002);
        cmd(6'h07, 4'h1, 2'h0, 16'h0010);
        cmd(6'h07, 4'h2, 2'h1, 16'hfffe);
        check({15'h0, chan_busy}, 16'h0001);
        wait_words(2);
        check(16'(wcnt), 16'h0002);
        check({15'h0, chan_busy}, 16'h0000);
        rd(3'h3);
        check({15'h0, rd_val[2]}, 16'h0001);
        cmd(6'h07, 4'h8, 2'h0, 16'h0000);
        rd(3'h3);
        check({14'h0, rd_val[4:3]}, 16'h0002);
        cmd(6'h07, 4'h4, 2'h0, 16'h0000);
        rd(3'h2);
        check(rd_val, 16'h0012);
        cmd(6'h07, 4'h5, 2'h0, 16'h0000);
        rd(3'h2);
        check(rd_val, 16'h8002);
        cmd(6'h00, 4'ha, 2'h0, 16'h0000);
        rd(3'h2);
        check(rd_val, 16'h0007);
        cmd(6'h00, 4'h9, 2'h0, 16'h0080);
        rd(3'h3);
        check({15'h0, rd_val[2]}, 16'h0000);
        cmd(6'h00, 4'h9, 2'h0, 16'h0000);
        rd(3'h3);
        check({15'h0, rd_val[2]}, 16'h0001);
        cmd(6'h07, 4'h7, 2'h2, 16'h0000);
        cmd(6'h07, 4'h8, 2'h0, 16'h0000);
        rd(3'h3);
        check({13'h0, rd_val[4:2]}, 16'h0000);
        chk_out = 1'b0;
    endtask
    task automatic t_chan_in();
        @(posedge sys_clk);
        chan_word_in <= 16'h1234;
        cmd(6'h07, 4'h3, 2'h0, 16'h0005);
        cmd(6'h07, 4'h1, 2'h0, 16'h0020);
        cmd(6'h07, 4'h2, 2'h1, 16'hffff);
        wait_words(3);
        check(chan_dev_select, 4'h5);
        cmd(6'h07, 4'h6, 2'h0, 16'h0000);
        rd(3'h2);
        check(rd_val, 16'h0005);
        wr(3'h4, 16'h0020);
        rd(3'h5);
        check(rd_val, 16'h1234);
        cmd(6'h00, 4'hb, 2'h0, 16'h0000);
        check(lamp_word, 16'ha5c3);
        cmd(6'h07, 4'h8, 2'h0, 16'h0000);
        rd(3'h3);
        check({13'h0, rd_val[4:2]}, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        sys_rst = 1'b1;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        sw_addr = 3'h0;
        sw_wdata = 16'h0000;
        radar_lines = 3'b010;
        radar_fitted = 1'b1;
        sens_level = 3'h0;
        altitude_code = 10'h000;
        chan_user_req = 1'b1;
        chan_word_in = 16'h0000;
        chk_out = 1'b0;
        exp_word[0] = 16'h1111;
        exp_word[1] = 16'h2222;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_idle();
        t_lamp();
        t_input();
        t_chan_out();
        t_chan_in();
        conclude();
    end
endmodule
`default_nettype wire

/* File: verification/iob_sva.sv */
// concurrent checks on the io bus between the cpu end and the device end
`timescale 1ns/1ps
`default_nettype none
module iob_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // cpu end
    input wire logic [5:0] code,
    input wire logic [15:0] dout,
    input wire iob_pkg::iob_op_t op,
    input wire logic int_prio_in,
    input wire logic dch_prio_in,
    input wire logic dch_ack,
    input wire logic dch_addr_stb,
    // device end
    input wire logic [15:0] din,
    input wire logic din_oe,
    input wire logic skip_busy,
    input wire logic skip_done,
    input wire logic int_req,
    input wire logic int_prio_out,
    input wire logic dch_req,
    input wire logic dch_prio_out
);
    import iob_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_done_not_busy: assert property (!(skip_busy && skip_done))
        else $error("busy and done reported together");
    a_int_chain_break: assert property (int_prio_out == (int_prio_in && !int_req))
        else $error("interrupt chain not broken by requester");
    a_dch_chain_break: assert property (dch_prio_out == (dch_prio_in && !dch_req))
        else $error("channel chain not broken by requester");
    a_drive_one_cycle: assert property (din_oe |=> !din_oe)
        else $error("data lines driven longer than one cycle");
    a_pio_read_answer: assert property (op == op_read_a && code == 6'h06 |=> din_oe)
        else $error("port a read of code 6 not answered");
    a_ack_gives_code: assert property (op == op_interrupt_acknowledge && int_req |=> din_oe && din == 16'h0007)
        else $error("acknowledge did not return the device code");
    a_skip_other_code: assert property (op == op_skip_test && code != 6'h07 |=> !skip_busy && !skip_done)
        else $error("skip test answered for a code without flags");
    a_chan_cycle_order: assert property (dch_ack |=> dch_addr_stb ##1 din_oe)
        else $error("channel address not supplied after strobe");
    a_req_granted: assert property ($rose(dch_req) |-> ##[1:4] dch_ack)
        else $error("channel request not granted");
    a_mask_disables: assert property (op == op_mask_out && dout[7] |=> !int_req)
        else $error("mask bit did not disable the request");
    a_bus_reset_idle: assert property (op == op_bus_reset |=> !int_req)
        else $error("bus reset left an interrupt request");
endmodule
`default_nettype wire
